/* File: src/net_flags_defines.svh */
/*
 * register map, field positions, reset values and timing counts of
 * the network status and diagnostic flag bank.
 * assumes a 250 MHz clock and 32-bit classic wishbone.
 */
`ifndef NET_FLAGS_DEFINES_SVH
`define NET_FLAGS_DEFINES_SVH
// word offsets on the wishbone bus
`define OFS_STATUS   4'h0
`define OFS_DIAG     4'h1
`define OFS_MASK     4'h2
`define OFS_CONTROL  4'h3
`define OFS_COMMAND  4'h4
`define OFS_NEXT_ID  4'h5
// status and diagnostic bit positions
`define ST_AVAIL     0
`define ST_ACKED     1
`define ST_IDLE      2
`define ST_TEST      3
`define ST_POR       4
`define ST_BLOCKED   7
`define DG_SUCC      1
`define DG_PROBE     2
`define DG_EXCESS    3
`define DG_TOKEN     4
`define DG_ACT       5
`define DG_DUP       6
`define DG_SELF      7
// command bits
`define CMD_CLEAR    0
`define CMD_PORCLR   1
`define CMD_TX_EN    2
`define CMD_TX_DIS   3
`define CMD_RX_EN    4
// control bits
`define CTL_TX_ON    0
`define CTL_FOUR     1
// reset values
`define STATUS_RST   8'h91
`define DIAG_RST     8'h00
// refusal thresholds
`define NAK_MANY     8'h80
`define NAK_FEW      8'h04
// line idle time
`define IDLE_NS      41000
`define CLK_NS       4
`define IDLE_CYC     ((`IDLE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

/* File: src/net_flags_pkg.sv */
/*
 * types shared by the flag bank.
 * assumes the defines header for all numeric constants.
 */
package net_flags_pkg;
	typedef logic [7:0] flag_reg_type;
	typedef enum logic [2:0] {
		SEL_STATUS, SEL_DIAG, SEL_MASK, SEL_CONTROL,
		SEL_COMMAND, SEL_NEXT_ID, SEL_NONE
	} reg_sel_type;
endpackage

/* File: src/network_status_diag_flags.sv */
/*
 * status and diagnostic flag bank with wishbone slave and masked
 * interrupt. assumes protocol engine pulses are one cycle wide on clk,
 * line_receive_input is asynchronous.
 */
`include "net_flags_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module network_status_diag_flags #(
	parameter int IDLE_CYCLES = `IDLE_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        soft_reset,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// line pin
	input  wire logic        line_receive_input,
	// protocol engine events
	input  wire logic        tx_last_byte,
	input  wire logic        tx_ack_seen,
	input  wire logic        tx_broadcast,
	input  wire logic        token_received,
	input  wire logic        lost_token_timeout,
	input  wire logic        dup_match_resp,
	input  wire logic        foreign_token,
	input  wire logic        refusal_seen,
	input  wire logic        probe_match_resp,
	input  wire logic        successor_update,
	input  wire logic        rx_packet_stored,
	input  wire logic [7:0]  successor_id,
	// interrupt
	output logic             irq
);
	// bus decode
	net_flags_pkg::reg_sel_type sel;
	logic       acc;
	logic       wr;
	logic       rd;
	logic       next_ack;
	logic [7:0] next_rdata;
	logic [7:0] rdata;
	logic       clr;
	// flags and setup
	net_flags_pkg::flag_reg_type status, next_status;
	net_flags_pkg::flag_reg_type diag, next_diag;
	net_flags_pkg::flag_reg_type mask, next_mask;
	logic [1:0]  control, next_control;
	logic        avail_pend, next_avail_pend;
	logic [7:0]  nak_cnt, next_nak_cnt;
	logic [7:0]  nak_lim;
	// line sampling
	logic [2:0]  rx_sync, next_rx_sync;
	logic        rx_level, next_rx_level;
	logic [13:0] idle_cnt, next_idle_cnt;
	logic        idle_hit;
	logic [7:0]  cmd;

	assign clr = !rst_n || soft_reset;

	// decode; the access takes effect at the edge where ack is high
	always_comb begin
		case (wb_adr_i[3:0])
			`OFS_STATUS:  sel = net_flags_pkg::SEL_STATUS;
			`OFS_DIAG:    sel = net_flags_pkg::SEL_DIAG;
			`OFS_MASK:    sel = net_flags_pkg::SEL_MASK;
			`OFS_CONTROL: sel = net_flags_pkg::SEL_CONTROL;
			`OFS_COMMAND: sel = net_flags_pkg::SEL_COMMAND;
			`OFS_NEXT_ID: sel = net_flags_pkg::SEL_NEXT_ID;
			default:      sel = net_flags_pkg::SEL_NONE;
		endcase
		if (wb_adr_i[5:4] != 2'h0)
			sel = net_flags_pkg::SEL_NONE;
		acc = wb_cyc_i && wb_stb_i && wb_ack_o;
		wr  = acc && wb_we_i && wb_sel_i[0];
		rd  = acc && !wb_we_i;
		cmd = (wr && sel == net_flags_pkg::SEL_COMMAND) ?
			wb_dat_i[7:0] : 8'h00;
	end

	// ack one cycle after the request, read data captured with it
	always_comb begin
		next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
		case (sel)
			net_flags_pkg::SEL_STATUS:  next_rdata = status;
			net_flags_pkg::SEL_DIAG:    next_rdata = diag;
			net_flags_pkg::SEL_MASK:    next_rdata = mask;
			net_flags_pkg::SEL_CONTROL: next_rdata = {6'h00, control};
			net_flags_pkg::SEL_NEXT_ID: next_rdata = successor_id;
			default:                    next_rdata = 8'h00;
		endcase
		if (!next_ack)
			next_rdata = rdata;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			rdata    <= 8'h00;
		end else begin
			wb_ack_o <= next_ack;
			rdata    <= next_rdata;
		end
	end
	assign wb_dat_o = {24'h000000, rdata};

	// receive pin: three stages, a change counts once stages 2 and 3 agree
	always_comb begin
		next_rx_sync  = {rx_sync[1:0], line_receive_input};
		next_rx_level = (rx_sync[1] == rx_sync[2]) ? rx_sync[2] : rx_level;
		// the count stops at the limit so one idle stretch flags once
		idle_hit      = !rx_level &&
			(idle_cnt == 14'(IDLE_CYCLES - 1));
		if (rx_level)
			next_idle_cnt = 14'h0000;
		else if (idle_cnt < 14'(IDLE_CYCLES))
			next_idle_cnt = idle_cnt + 14'h0001;
		else
			next_idle_cnt = idle_cnt;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_sync  <= 3'h0;
			rx_level <= 1'b0;
			idle_cnt <= 14'h0000;
		end else begin
			rx_sync  <= next_rx_sync;
			rx_level <= next_rx_level;
			idle_cnt <= next_idle_cnt;
		end
	end

	// flags: every clear comes first so that a set in the same cycle wins
	always_comb begin
		next_status  = status;
		next_diag    = diag;
		next_mask    = mask;
		next_control = control;
		next_avail_pend = avail_pend;
		next_nak_cnt = nak_cnt;
		nak_lim = control[`CTL_FOUR] ? `NAK_FEW : `NAK_MANY;
		if (wr && sel == net_flags_pkg::SEL_MASK)
			next_mask = wb_dat_i[7:0];
		if (wr && sel == net_flags_pkg::SEL_CONTROL)
			next_control = wb_dat_i[1:0];
		// status clears
		if (cmd[`CMD_CLEAR] || cmd[`CMD_PORCLR]) begin
			next_status[`ST_IDLE] = 1'b0;
			next_status[`ST_POR]  = 1'b0;
		end
		if (cmd[`CMD_TX_EN]) begin
			next_status[`ST_ACKED] = 1'b0;
			next_avail_pend = 1'b1;
			next_nak_cnt = 8'h00;
		end
		if (avail_pend && token_received) begin
			next_status[`ST_AVAIL] = 1'b0;
			next_avail_pend = 1'b0;
		end
		if (cmd[`CMD_RX_EN])
			next_status[`ST_BLOCKED] = 1'b0;
		// status sets
		if (idle_hit)
			next_status[`ST_IDLE] = 1'b1;
		if (tx_ack_seen && !tx_broadcast)
			next_status[`ST_ACKED] = 1'b1;
		if (tx_last_byte || cmd[`CMD_TX_DIS]) begin
			next_status[`ST_AVAIL] = 1'b1;
			next_avail_pend = 1'b0;
		end
		if (rx_packet_stored)
			next_status[`ST_BLOCKED] = 1'b1;
		next_status[6:5]      = 2'h0;
		next_status[`ST_TEST] = 1'b0;
		// diagnostic clears on read, except excess refusal and successor
		if (rd && sel == net_flags_pkg::SEL_DIAG) begin
			next_diag[`DG_SELF]  = 1'b0;
			next_diag[`DG_DUP]   = 1'b0;
			next_diag[`DG_ACT]   = 1'b0;
			next_diag[`DG_TOKEN] = 1'b0;
			next_diag[`DG_PROBE] = 1'b0;
		end
		if (cmd[`CMD_PORCLR] || status[`ST_AVAIL])
			next_diag[`DG_EXCESS] = 1'b0;
		if (rd && sel == net_flags_pkg::SEL_NEXT_ID)
			next_diag[`DG_SUCC] = 1'b0;
		// refusal counter saturates at the threshold
		if (refusal_seen && nak_cnt < nak_lim)
			next_nak_cnt = nak_cnt + 8'h01;
		// diagnostic sets
		if (lost_token_timeout)
			next_diag[`DG_SELF] = 1'b1;
		if (dup_match_resp || (control[`CTL_TX_ON] && token_received))
			next_diag[`DG_DUP] = 1'b1;
		if (rx_level)
			next_diag[`DG_ACT] = 1'b1;
		if (foreign_token)
			next_diag[`DG_TOKEN] = 1'b1;
		if (refusal_seen && nak_cnt == nak_lim - 8'h01)
			next_diag[`DG_EXCESS] = 1'b1;
		if (probe_match_resp)
			next_diag[`DG_PROBE] = 1'b1;
		if (successor_update)
			next_diag[`DG_SUCC] = 1'b1;
		next_diag[0] = 1'b0;
	end

	// software reset restores the flags but keeps mask and control
	always_ff @(posedge clk) begin
		if (clr) begin
			status     <= `STATUS_RST;
			diag       <= `DIAG_RST;
			avail_pend <= 1'b0;
			nak_cnt    <= 8'h00;
		end else begin
			status     <= next_status;
			diag       <= next_diag;
			avail_pend <= next_avail_pend;
			nak_cnt    <= next_nak_cnt;
		end
		if (!rst_n) begin
			mask    <= 8'h00;
			control <= 2'h0;
		end else begin
			mask    <= next_mask;
			control <= next_control;
		end
	end

	// interrupt is a level from the idle, available, blocked, excess refusal and successor flags, masked per bit
	assign irq = (status[`ST_IDLE] && mask[`ST_IDLE]) ||
		(status[`ST_AVAIL] && mask[`ST_AVAIL]) ||
		(status[`ST_BLOCKED] && mask[`ST_BLOCKED]) ||
		(diag[`DG_EXCESS] && mask[`DG_EXCESS]) ||
		(diag[`DG_SUCC] && mask[`DG_SUCC]);

	// checks
	sequence s_diag_read;
		rd && sel == net_flags_pkg::SEL_DIAG;
	endsequence
	sequence s_no_late_set;
		!lost_token_timeout && !foreign_token;
	endsequence
	property p_test_zero;
		@(posedge clk) disable iff (!rst_n) !status[`ST_TEST];
	endproperty
	a_test_zero: assert property (p_test_zero)
		else $error("status test bit set");
	property p_idle;
		@(posedge clk) disable iff (clr) idle_hit |=> status[`ST_IDLE];
	endproperty
	a_idle: assert property (p_idle)
		else $error("idle timeout did not set reconfig flag");
	// checks the set path and the mask together, not just the gate
	property p_irq;
		@(posedge clk) disable iff (clr)
		(successor_update && mask[`DG_SUCC] && !wr) |=> irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("masked successor flag without irq");
	property p_bcast;
		@(posedge clk) disable iff (clr)
		(!status[`ST_ACKED] && tx_broadcast) |=> !status[`ST_ACKED];
	endproperty
	a_bcast: assert property (p_bcast)
		else $error("broadcast acknowledged");
	property p_tx_en;
		@(posedge clk) disable iff (clr)
		(cmd[`CMD_TX_EN] && !tx_ack_seen) |=> !status[`ST_ACKED];
	endproperty
	a_tx_en: assert property (p_tx_en)
		else $error("enable transmit left ack flag");
	property p_diag_read;
		@(posedge clk) disable iff (clr)
		(s_diag_read and s_no_late_set) |=>
		!diag[`DG_SELF] && !diag[`DG_TOKEN];
	endproperty
	a_diag_read: assert property (p_diag_read)
		else $error("diag read did not clear");
	property p_keep;
		@(posedge clk) disable iff (clr)
		(s_diag_read and diag[`DG_SUCC] && !wb_adr_i[2])
		|=> diag[`DG_SUCC];
	endproperty
	a_keep: assert property (p_keep)
		else $error("successor flag lost on diag read");
	property p_reset;
		@(posedge clk) $rose(rst_n) |-> status == `STATUS_RST &&
		diag == `DIAG_RST;
	endproperty
	a_reset: assert property (p_reset)
		else $error("reset value wrong");
	property p_excess_avail;
		@(posedge clk) disable iff (clr)
		(status[`ST_AVAIL] && !refusal_seen) |=> !diag[`DG_EXCESS];
	endproperty
	a_excess_avail: assert property (p_excess_avail)
		else $error("excess refusal kept with tx available high");
endmodule
`default_nettype wire

/* File: bench/wb_host_model.sv */
/*
 * host processor model: classic wishbone master with one access task.
 * assumes the slave answers with ack and the caller enters just after
 * a rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module wb_host_model (
	// bus clock
	input  wire logic        clk,
	// wishbone master side
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [5:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      dat,
	input  wire logic [31:0] dat_in,
	input  wire logic        ack
);
	// idle bus from time zero
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 6'h00;
		sel = 4'h0;
		dat = 32'h0;
	end

	// hold the request until ack; only the bench watchdog ends a wait
	task automatic access(input logic w, input logic [5:0] a,
		input logic [7:0] d, output logic [7:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat <= {24'h0, d};
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = dat_in[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

/* File: bench/tb_network_status_diag_flags.sv */
/*
 * self-checking bench for the flag bank: register reads and writes via
 * the host model, event pulses from a stand-in protocol engine.
 * assumes a short idle timer of 20 cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_network_status_diag_flags;
	logic        clk;
	logic        rst_n;
	logic        cyc, stb, we, ack, irq, bc, line_in;
	logic [5:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	logic [9:0]  ev;
	logic        soft_rst;
	int          fails;
	int          n_checks;

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	network_status_diag_flags #(.IDLE_CYCLES(20)) network_status_diag_flags_i (
		.clk(clk), .rst_n(rst_n), .soft_reset(soft_rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.line_receive_input(line_in), .tx_last_byte(ev[0]),
		.tx_ack_seen(ev[1]), .tx_broadcast(bc), .token_received(ev[2]),
		.lost_token_timeout(ev[3]), .dup_match_resp(ev[4]),
		.foreign_token(ev[5]), .refusal_seen(ev[6]),
		.probe_match_resp(ev[7]), .successor_update(ev[8]),
		.rx_packet_stored(ev[9]), .successor_id(8'h5a), .irq(irq));

	wb_host_model wb_host_model_i (
		.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
		.dat(wdat), .dat_in(rdat), .ack(ack));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// masked read compare; the mask skips bits another scenario owns
	task automatic rd(input logic [5:0] a, input logic [7:0] m,
		input logic [7:0] exp);
		logic [7:0] v;
		wb_host_model_i.access(1'b0, a, 8'h00, v);
		chk(v & m, exp);
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] v;
		wb_host_model_i.access(1'b1, a, d, v);
	endtask

	// one-cycle event pulse, then one edge for the flag to land
	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev <= '0;
		@(posedge clk);
	endtask

	task automatic print_verdict;
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// hang guard, far above the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		print_verdict;
	end

	initial begin
		rst_n = 1'b0;
		bc = 1'b0;
		line_in = 1'b0;
		ev = '0;
		soft_rst = 1'b0;
		fails = 0;
		n_checks = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(6'h00, 8'hff, 8'h91);
		rd(6'h01, 8'hff, 8'h00);
		// idle line runs the timer out
		wr(6'h02, 8'h04);
		repeat (40) @(posedge clk);
		rd(6'h00, 8'h0c, 8'h04);
		@(negedge clk) chk({7'h0, irq}, 8'h01);
		@(posedge clk);
		line_in <= 1'b1;
		repeat (8) @(posedge clk);
		wr(6'h04, 8'h01);
		rd(6'h00, 8'h04, 8'h00);
		rd(6'h01, 8'h20, 8'h20);
		line_in <= 1'b0;
		repeat (8) @(posedge clk);
		rd(6'h01, 8'hff, 8'h20);
		rd(6'h01, 8'hff, 8'h00);
		wr(6'h02, 8'h00);
		// transmit sequence, broadcast ack ignored
		wr(6'h04, 8'h04);
		rd(6'h00, 8'h03, 8'h01);
		pulse(2);
		rd(6'h00, 8'h03, 8'h00);
		bc <= 1'b1;
		pulse(1);
		bc <= 1'b0;
		rd(6'h00, 8'h03, 8'h00);
		pulse(1);
		rd(6'h00, 8'h03, 8'h02);
		pulse(0);
		rd(6'h00, 8'h03, 8'h03);
		wr(6'h04, 8'h04);
		rd(6'h00, 8'h02, 8'h00);
		pulse(2);
		// four refusals in the reduced setting while tx is busy
		wr(6'h03, 8'h02);
		repeat (3) pulse(6);
		rd(6'h01, 8'h08, 8'h00);
		pulse(6);
		rd(6'h01, 8'h08, 8'h08);
		rd(6'h01, 8'h08, 8'h08);
		wr(6'h02, 8'h08);
		@(negedge clk) chk({7'h0, irq}, 8'h01);
		@(posedge clk);
		wr(6'h04, 8'h02);
		rd(6'h01, 8'h08, 8'h00);
		// full threshold after re-enabling transmit, then tx available
		// set by the disable transmit command must wipe the flag
		wr(6'h04, 8'h04);
		pulse(2);
		wr(6'h03, 8'h00);
		repeat (127) pulse(6);
		rd(6'h01, 8'h08, 8'h00);
		pulse(6);
		rd(6'h01, 8'h08, 8'h08);
		wr(6'h04, 8'h08);
		rd(6'h01, 8'h08, 8'h00);
		rd(6'h00, 8'h01, 8'h01);
		// on line: every token marks the duplicate flag
		wr(6'h03, 8'h01);
		pulse(2);
		rd(6'h01, 8'h40, 8'h40);
		rd(6'h01, 8'h40, 8'h00);
		// receiver enabled; successor and blocked flags unmasked
		wr(6'h04, 8'h10);
		wr(6'h02, 8'h82);
		for (int i = 3; i < 9; i++) begin
			if (i != 6)
				pulse(i);
		end
		rd(6'h01, 8'hff, 8'hd6);
		rd(6'h01, 8'hff, 8'h02);
		rd(6'h05, 8'hff, 8'h5a);
		rd(6'h01, 8'hff, 8'h00);
		@(negedge clk) chk({7'h0, irq}, 8'h00);
		@(posedge clk);
		pulse(9);
		rd(6'h00, 8'h80, 8'h80);
		@(negedge clk) chk({7'h0, irq}, 8'h01);
		@(posedge clk);
		// software reset restores the flags but keeps the mask
		pulse(3);
		pulse(8);
		soft_rst <= 1'b1;
		@(posedge clk);
		soft_rst <= 1'b0;
		rd(6'h00, 8'hff, 8'h91);
		rd(6'h01, 8'hff, 8'h00);
		rd(6'h02, 8'hff, 8'h82);
		rd(6'h3f, 8'hff, 8'h00);
		print_verdict;
	end
endmodule
`default_nettype wire
